// [design/dbu_regs.sv]
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
module dbu_regs #(
  parameter logic [3:0] PROC_CODE   = 4'h5, // arbitrary value
  parameter logic [4:0] FAMILY_CODE = 5'h0a, // arbitrary value
  parameter logic [5:0] SERIES_CODE = 6'h15, // arbitrary value
  parameter logic [3:0] DIE_CODE    = 4'h7, // arbitrary value
  parameter logic [3:0] REV_CODE    = 4'h2, // arbitrary value
  parameter logic [7:0] SEL_CODE    = 8'h3c  // arbitrary value
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic        op_start_in,
  input  wire logic        op_self_test_in,
  input  wire logic        op_done_in,
  input  wire logic [31:0] op_result_in,
  output logic      [31:0] rdata_out,
  output logic      [29:0] start_word_out,
  output logic      [1:0]  access_mode_select_out,
  output logic      [29:0] length_words_out,
  output logic      [31:0] seed_out,
  output logic             checksum_mode_out,
  output logic             self_test_mode_out,
  output logic             mailbox_dirty_flag0_out,
  output logic             mailbox_dirty_flag1_out
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [31:0]     start_loc;
    logic [31:0]     length;
    logic [31:0]     data;
    logic            guard;
    logic            busy;
    logic            ck_mode;
    logic            st_mode;
    dbu_pkg::dbu_op_t op;
    logic [31:0]     rdata;
  } dbu_state_t;

  dbu_state_t st_q;
  dbu_state_t st_d;

  localparam dbu_state_t RST_STATE = '{
    start_loc: dbu_pkg::ZERO_RST,
    length:    dbu_pkg::ZERO_RST,
    data:      dbu_pkg::ZERO_RST,
    guard:     1'b0,
    busy:      1'b0,
    ck_mode:   1'b0,
    st_mode:   1'b0,
    op:        dbu_pkg::DBU_OP_NONE,
    rdata:     dbu_pkg::ZERO_RST
  };

  logic [31:0] mbox0_w;
  logic [31:0] mbox1_w;
  logic        dirty0_w;
  logic        dirty1_w;
  logic [31:0] ident_w;
  logic        wr_open_w;
  logic        wr_guard_w;
  logic        wr_mbox0_w;
  logic        wr_mbox1_w;
  logic        rd_mbox0_w;
  logic        rd_mbox1_w;
  logic        launch_w;
  logic        finish_w;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // ************************************************************
  // identity word
  // ************************************************************
  always_comb begin
    ident_w = '0;
    ident_w[dbu_pkg::PROC_LSB +: 4]   = PROC_CODE;
    ident_w[dbu_pkg::FAMILY_LSB +: 5] = FAMILY_CODE;
    ident_w[dbu_pkg::SERIES_LSB +: 6] = SERIES_CODE;
    ident_w[dbu_pkg::DIE_LSB +: 4]    = DIE_CODE;
    ident_w[dbu_pkg::REV_LSB +: 4]    = REV_CODE;
    ident_w[dbu_pkg::SEL_LSB +: 8]    = SEL_CODE;
    ident_w = ident_w & dbu_pkg::IDENT_MASK;
  end

  // ************************************************************
  // strobe decode
  // ************************************************************
  always_comb begin
    wr_open_w  = wr_in && !st_q.guard;
    wr_guard_w = wr_in && hit(addr_in, dbu_pkg::GUARD_OFS);
    wr_mbox0_w = wr_in && hit(addr_in, dbu_pkg::MBOX0_OFS);
    wr_mbox1_w = wr_in && hit(addr_in, dbu_pkg::MBOX1_OFS);
    rd_mbox0_w = rd_in && hit(addr_in, dbu_pkg::MBOX0_OFS);
    rd_mbox1_w = rd_in && hit(addr_in, dbu_pkg::MBOX1_OFS);
    launch_w   = op_start_in && !st_q.busy;
    finish_w   = op_done_in && st_q.busy;
  end

  // ************************************************************
  // mailboxes
  // ************************************************************
  dbu_mailbox #(.WIDTH(32)) u_mbox0 (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .wr_in      (wr_mbox0_w),
    .rd_in      (rd_mbox0_w),
    .wdata_in   (wdata_in),
    .word_out   (mbox0_w),
    .dirty_out  (dirty0_w)
  );

  dbu_mailbox #(.WIDTH(32)) u_mbox1 (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .wr_in      (wr_mbox1_w),
    .rd_in      (rd_mbox1_w),
    .wdata_in   (wdata_in),
    .word_out   (mbox1_w),
    .dirty_out  (dirty1_w)
  );

  // ************************************************************
  // register file and operation tracking
  // ************************************************************
  always_comb begin
    st_d = st_q;
    st_d.rdata = '0;
    if (wr_open_w) begin
      if (hit(addr_in, dbu_pkg::START_LOC_OFS)) begin
        st_d.start_loc = wdata_in;
      end
      if (hit(addr_in, dbu_pkg::LENGTH_OFS)) begin
        st_d.length = wdata_in & dbu_pkg::LENGTH_MASK;
      end
      if (hit(addr_in, dbu_pkg::DATA_OFS)) begin
        st_d.data = wdata_in;
      end
    end
    if (wr_guard_w) begin
      st_d.guard = wdata_in[0];
    end
    // mode meaning latched per operation kind
    if (launch_w) begin
      st_d.busy    = 1'b1;
      st_d.op      = op_self_test_in ? dbu_pkg::DBU_OP_SELF_TEST
                                     : dbu_pkg::DBU_OP_CHECKSUM;
      st_d.st_mode = op_self_test_in;
      st_d.ck_mode = !op_self_test_in;
    end else if (finish_w) begin
      st_d.busy    = 1'b0;
      st_d.st_mode = 1'b0;
      st_d.ck_mode = 1'b0;
      st_d.data    = op_result_in;
    end
    if (rd_in) begin
      unique case (addr_in)
        dbu_pkg::START_LOC_OFS: st_d.rdata = st_q.start_loc;
        dbu_pkg::LENGTH_OFS:    st_d.rdata = st_q.length;
        dbu_pkg::DATA_OFS:      st_d.rdata = st_q.data;
        dbu_pkg::MBOX0_OFS:     st_d.rdata = mbox0_w;
        dbu_pkg::MBOX1_OFS:     st_d.rdata = mbox1_w;
        dbu_pkg::IDENT_OFS:     st_d.rdata = ident_w;
        dbu_pkg::DIRTY_OFS:     st_d.rdata = {30'h0, dirty1_w, dirty0_w};
        dbu_pkg::GUARD_OFS:     st_d.rdata = {31'h0, st_q.guard};
        dbu_pkg::RESULT_OFS:    st_d.rdata = {30'h0, st_q.op};
        default:                st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_q <= RST_STATE;
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign rdata_out               = st_q.rdata;
  assign start_word_out          = st_q.start_loc[31:dbu_pkg::WORD_LSB];
  assign access_mode_select_out  = st_q.start_loc[dbu_pkg::MODE_MSB:0];
  assign length_words_out        = st_q.length[31:dbu_pkg::WORD_LSB];
  assign seed_out                = st_q.data;
  assign checksum_mode_out       = st_q.ck_mode;
  assign self_test_mode_out      = st_q.st_mode;
  assign mailbox_dirty_flag0_out = dirty0_w;
  assign mailbox_dirty_flag1_out = dirty1_w;

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_read(logic [7:0] ofs);
    rd_in && addr_in == ofs;
  endsequence
  sequence s_write_open(logic [7:0] ofs);
    wr_open_w && addr_in == ofs;
  endsequence
  sequence s_write_shut(logic [7:0] ofs);
    wr_in && st_q.guard && addr_in == ofs;
  endsequence
  sequence s_read_ident;
    rd_in && addr_in == dbu_pkg::IDENT_OFS;
  endsequence
  sequence s_launch(logic kind);
    launch_w && op_self_test_in == kind;
  endsequence

  start_store_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_write_open(dbu_pkg::START_LOC_OFS)
    |=> start_word_out == $past(wdata_in[31:2]))
    else $error("start word not stored");
  start_mode_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_write_open(dbu_pkg::START_LOC_OFS)
    |=> access_mode_select_out == $past(wdata_in[1:0]))
    else $error("access mode not stored");
  start_guard_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_write_shut(dbu_pkg::START_LOC_OFS)
    |=> $stable(start_word_out) && $stable(access_mode_select_out))
    else $error("guarded start write took effect");
  start_read_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_read(dbu_pkg::START_LOC_OFS)
    |=> rdata_out == {$past(start_word_out), $past(access_mode_select_out)})
    else $error("start read back wrong");

  mode_latch_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_launch(1'b1)
    |=> self_test_mode_out && !checksum_mode_out)
    else $error("self test mode not entered");
  checksum_latch_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_launch(1'b0)
    |=> checksum_mode_out && !self_test_mode_out)
    else $error("checksum mode not entered");
  mode_excl_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    !(checksum_mode_out
    && self_test_mode_out))
    else $error("both operation modes active");

  length_low_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_read(dbu_pkg::LENGTH_OFS)
    |=> rdata_out[1:0] == 2'h0)
    else $error("length low bits not zero");
  length_store_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_write_open(dbu_pkg::LENGTH_OFS)
    |=> length_words_out == $past(wdata_in[31:2]))
    else $error("length not stored");
  length_guard_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_write_shut(dbu_pkg::LENGTH_OFS)
    |=> $stable(length_words_out))
    else $error("guarded length write took effect");
  length_read_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_read(dbu_pkg::LENGTH_OFS)
    |=> rdata_out[31:2] == $past(length_words_out))
    else $error("length read back wrong");

  result_load_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    finish_w |=> seed_out == $past(op_result_in)
    && !checksum_mode_out && !self_test_mode_out)
    else $error("result not left in data word");
  data_store_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_write_open(dbu_pkg::DATA_OFS) ##0 !finish_w
    |=> seed_out == $past(wdata_in))
    else $error("data word not stored");
  data_guard_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_write_shut(dbu_pkg::DATA_OFS) ##0 !finish_w
    |=> $stable(seed_out))
    else $error("guarded data write took effect");
  data_read_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_read(dbu_pkg::DATA_OFS)
    |=> rdata_out == $past(seed_out))
    else $error("data read back wrong");

  mbox_guard_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_write_shut(dbu_pkg::MBOX1_OFS)
    |=> mbox1_w == $past(wdata_in))
    else $error("mailbox blocked by guard");
  mbox_read_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_read(dbu_pkg::MBOX0_OFS)
    |=> rdata_out == $past(mbox0_w))
    else $error("mailbox read back wrong");
  dirty_view_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    wr_mbox1_w
    |=> mailbox_dirty_flag1_out)
    else $error("dirty flag one not set");
  dirty_drop_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    rd_mbox0_w && !wr_mbox0_w
    |=> !mailbox_dirty_flag0_out)
    else $error("dirty flag zero not cleared");
  dirty_read_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_read(dbu_pkg::DIRTY_OFS)
    |=> rdata_out[1:0] == {$past(dirty1_w), $past(dirty0_w)})
    else $error("dirty flags read back wrong");

  ident_read_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_read_ident |=> rdata_out[31:28] == PROC_CODE
    && rdata_out[15:8] == {DIE_CODE, REV_CODE})
    else $error("identity fields wrong");
  ident_mid_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_read_ident
    |=> rdata_out[27:16] == {FAMILY_CODE, 1'b0, SERIES_CODE})
    else $error("family or series wrong");
  ident_sel_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    s_read_ident
    |=> rdata_out[7:0] == SEL_CODE && !rdata_out[22])
    else $error("selector or reserved bit wrong");
endmodule

// [design/dbu_pkg.sv]
package dbu_pkg;
  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] START_LOC_OFS   = 8'h04;
  localparam logic [7:0] LENGTH_OFS      = 8'h08;
  localparam logic [7:0] DATA_OFS        = 8'h0c;
  localparam logic [7:0] MBOX0_OFS       = 8'h10;
  localparam logic [7:0] MBOX1_OFS       = 8'h14;
  localparam logic [7:0] IDENT_OFS       = 8'h18;
  localparam logic [7:0] DIRTY_OFS       = 8'h1c;
  localparam logic [7:0] GUARD_OFS       = 8'h20;
  localparam logic [7:0] RESULT_OFS      = 8'h24;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int WORD_LSB      = 2;
  localparam int MODE_MSB      = 1;
  localparam int PROC_LSB      = 28;
  localparam int FAMILY_LSB    = 23;
  localparam int SERIES_LSB    = 16;
  localparam int DIE_LSB       = 12;
  localparam int REV_LSB       = 8;
  localparam int SEL_LSB       = 0;
  // ************************************************************
  // reset values and masks
  // ************************************************************
  localparam logic [31:0] ZERO_RST    = 32'h0000_0000;
  localparam logic [31:0] LENGTH_MASK = 32'hffff_fffc;
  localparam logic [31:0] IDENT_MASK  = 32'hffbf_ffff;
  // ************************************************************
  // access mode meaning per operation
  // ************************************************************
  typedef enum logic [1:0] {
    DBU_OP_NONE,
    DBU_OP_CHECKSUM,
    DBU_OP_SELF_TEST
  } dbu_op_t;
endpackage

// [design/dbu_mailbox.sv]
`timescale 1ns/100ps
module dbu_mailbox #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire logic             wr_in,
  input  wire logic             rd_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  output logic      [WIDTH-1:0] word_out,
  output logic                  dirty_out
);
  typedef struct packed {
    logic [WIDTH-1:0] word;
    logic             dirty;
  } dbu_mbox_t;

  dbu_mbox_t st_q;
  dbu_mbox_t st_d;

  if (WIDTH < 1) begin
    $error("mailbox width must be positive");
  end

  always_comb begin
    st_d = st_q;
    if (rd_in) begin
      st_d.dirty = 1'b0;
    end
    if (wr_in) begin
      st_d.word  = wdata_in;
      st_d.dirty = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign word_out  = st_q.word;
  assign dirty_out = st_q.dirty;

  dirty_set_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    wr_in |=> dirty_out && word_out == $past(wdata_in))
    else $error("mailbox write did not mark dirty");
  dirty_clr_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    rd_in && !wr_in |=> !dirty_out)
    else $error("mailbox read did not clear dirty");
endmodule

// [bench/dbu_op_model.sv]
`timescale 1ns/100ps
// ************************************************************
// operation engine on the far side of the operand registers
// ************************************************************
module dbu_op_model (
  input  wire logic        clk_sys_in,
  output logic             op_start_out,
  output logic             op_self_test_out,
  output logic             op_done_out,
  output logic      [31:0] op_result_out
);
  initial begin
    op_start_out     = 1'b0;
    op_self_test_out = 1'b0;
    op_done_out      = 1'b0;
    op_result_out    = 32'h0000_0000;
  end
  // start pulse, lat idle cycles, then a one-cycle result pulse
  task automatic run(input logic kind, input logic [31:0] res,
                     input int lat);
    @(posedge clk_sys_in);
    op_start_out     <= 1'b1;
    op_self_test_out <= kind;
    @(posedge clk_sys_in);
    op_start_out     <= 1'b0;
    op_self_test_out <= ~kind;
    repeat (lat) @(posedge clk_sys_in);
    op_done_out   <= 1'b1;
    op_result_out <= res;
    @(posedge clk_sys_in);
    op_done_out   <= 1'b0;
    op_result_out <= ~res;
  endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/100ps
module tb;
  logic        clk_sys_in, rst_in, wr_in, rd_in, op_go, op_kind, op_end;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in, op_res, rdata_out, seed_out;
  logic [29:0] start_word_out, length_words_out;
  logic [1:0]  mode_out;
  logic        ck_mode, st_mode, dirty0, dirty1;
  int          err_total, checks_done;
  // identity fields below are arbitrary values
  localparam logic [31:0] ID_EXP = {4'h9, 5'h13, 1'b0, 6'h2e, 4'h4,
                                    4'h1, 8'h3c};
  dbu_regs #(.PROC_CODE(4'h9), .FAMILY_CODE(5'h13), .SERIES_CODE(6'h2e),
    .DIE_CODE(4'h4), .REV_CODE(4'h1)) u_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .op_start_in(op_go), .op_self_test_in(op_kind), .op_done_in(op_end),
    .op_result_in(op_res), .rdata_out(rdata_out),
    .start_word_out(start_word_out), .access_mode_select_out(mode_out),
    .length_words_out(length_words_out), .seed_out(seed_out),
    .checksum_mode_out(ck_mode), .self_test_mode_out(st_mode),
    .mailbox_dirty_flag0_out(dirty0), .mailbox_dirty_flag1_out(dirty1));
  dbu_op_model u_eng (.clk_sys_in(clk_sys_in), .op_start_out(op_go),
    .op_self_test_out(op_kind), .op_done_out(op_end),
    .op_result_out(op_res));
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // ************************************************************
  // bus cycles and comparison
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 chk($sformatf("read %h", a), rdata_out, exp);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    for (int i = 1; i < 10; i++) begin
      if (i != 6) rdc(8'(i * 4), 32'h0000_0000);
    end
    rdc(dbu_pkg::IDENT_OFS, ID_EXP);
  endtask
  task automatic t_fields();
    wr(dbu_pkg::START_LOC_OFS, 32'hffff_ffff);
    #1 chk("start word", 32'(start_word_out), 32'h3fff_ffff);
    chk("mode", 32'(mode_out), 32'h0000_0003);
    wr(dbu_pkg::START_LOC_OFS, 32'h0000_0012);
    #1 chk("start word", 32'(start_word_out), 32'h0000_0004);
    chk("mode", 32'(mode_out), 32'h0000_0002);
    rdc(dbu_pkg::START_LOC_OFS, 32'h0000_0012);
    wr(dbu_pkg::LENGTH_OFS, 32'hffff_ffff);
    rdc(dbu_pkg::LENGTH_OFS, 32'hffff_fffc);
    chk("length", 32'(length_words_out), 32'h3fff_ffff);
    wr(dbu_pkg::IDENT_OFS, 32'h0000_0000);
    rdc(dbu_pkg::IDENT_OFS, ID_EXP);
    wr(8'h30, 32'hdead_beef);
    rdc(8'h30, 32'h0000_0000);
  endtask
  task automatic t_mbox();
    wr(dbu_pkg::MBOX0_OFS, 32'ha5a5_0f0f);
    #1 chk("dirty", {dirty1, dirty0}, 32'h0000_0001);
    rdc(dbu_pkg::DIRTY_OFS, 32'h0000_0001);
    rdc(dbu_pkg::MBOX0_OFS, 32'ha5a5_0f0f);
    chk("dirty", {dirty1, dirty0}, 32'h0000_0000);
    wr(dbu_pkg::MBOX1_OFS, 32'h5a5a_f0f0);
    rdc(dbu_pkg::DIRTY_OFS, 32'h0000_0002);
    rdc(dbu_pkg::MBOX1_OFS, 32'h5a5a_f0f0);
    rdc(dbu_pkg::MBOX0_OFS, 32'ha5a5_0f0f);
    chk("dirty", {dirty1, dirty0}, 32'h0000_0000);
  endtask
  task automatic t_guard();
    wr(dbu_pkg::DATA_OFS, 32'h1111_2222);
    wr(dbu_pkg::GUARD_OFS, 32'h0000_0001);
    wr(dbu_pkg::DATA_OFS, 32'h3333_4444);
    rdc(dbu_pkg::DATA_OFS, 32'h1111_2222);
    rdc(dbu_pkg::GUARD_OFS, 32'h0000_0001);
    wr(dbu_pkg::START_LOC_OFS, 32'h0000_0ff0);
    rdc(dbu_pkg::START_LOC_OFS, 32'h0000_0012);
    wr(dbu_pkg::LENGTH_OFS, 32'h0000_0040);
    rdc(dbu_pkg::LENGTH_OFS, 32'hffff_fffc);
    wr(dbu_pkg::MBOX1_OFS, 32'h0000_0005);
    rdc(dbu_pkg::MBOX1_OFS, 32'h0000_0005);
    wr(dbu_pkg::GUARD_OFS, 32'h0000_0000);
    wr(dbu_pkg::DATA_OFS, 32'h3333_4444);
    #1 chk("seed", seed_out, 32'h3333_4444);
  endtask
  task automatic t_op(input logic kind, input logic [31:0] res);
    fork
      u_eng.run(kind, res, 4);
      begin
        repeat (2) @(posedge clk_sys_in);
        rdc(dbu_pkg::RESULT_OFS, kind ? 32'h2 : 32'h1);
        chk("kind", {st_mode, ck_mode}, kind ? 32'h2 : 32'h1);
      end
    join
    rdc(dbu_pkg::DATA_OFS, res);
    chk("seed", seed_out, res);
    chk("idle", {st_mode, ck_mode}, 32'h0000_0000);
  endtask
  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    err_total   = 0;
    checks_done = 0;
    rst_in      = 1'b1;
    wr_in       = 1'b0;
    rd_in       = 1'b0;
    addr_in     = 8'h00;
    wdata_in    = 32'h0000_0000;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_reset();
    t_fields();
    t_mbox();
    t_guard();
    t_op(1'b0, 32'hc0de_0001);
    t_op(1'b1, 32'hc0de_0002);
    give_verdict();
  end
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    err_total++;
    give_verdict();
  end
endmodule
